/* dmace_pkg.sv */
// package for the dma channel enable / transfer-end / interrupt block
// assumes a single 20 MHz clock domain and an apb register port
package dmace_pkg;

  // register byte offsets on the apb port
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPER = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // channel control field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_TE_BIT = 1;
  localparam int CTRL_IE_BIT = 2;
  localparam int CTRL_MODE_LSB = 3;

  // operation register field positions
  localparam int OPER_DME_BIT = 0;
  localparam int OPER_NMI_BIT = 1;
  localparam int OPER_AE_BIT = 2;

  // event positions and width of the sticky status and mask registers
  localparam int EV_DONE = 0;
  localparam int EV_NMI = 1;
  localparam int EV_AE = 2;
  localparam int EV_W = 3;

  // transfer counter
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // request modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_EXT = 2'h1;
  localparam logic [1:0] MODE_PERIPH = 2'h2;

  typedef struct packed {
    logic [1:0] mode;
    logic ie;
    logic te;
    logic go;
  } dmace_ctrl_s;

  typedef struct packed {
    logic ae;
    logic nmi_abort_flag;
    logic global_dma_on;
  } dmace_oper_s;

  localparam dmace_ctrl_s CTRL_RST = '{mode: 2'h0, ie: 1'b0, te: 1'b0,
                                       go: 1'b0};
  localparam dmace_oper_s OPER_RST = '{ae: 1'b0, nmi_abort_flag: 1'b0, global_dma_on: 1'b0};
  localparam logic [2:0] EV_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } dmace_state_e;

endpackage

/* dmace_channel.sv */
// dma channel control: enable, transfer-end flag and end-of-transfer irq
// assumes an apb master on clk; ext_req_n and nmi_in are asynchronous pins,
// periph_req and addr_err_in come from logic on clk
//
// Summary of operation
// - irq enable gates end-of-transfer request on transfer_done_irq, not on irq
// - count reaching zero sets end flag
// - nmi or address error leaves flag clear
// - software stop never sets end flag
// - set end flag blocks any new start
// - flag cleared by zero after one read
// - auto mode starts once both enables set and the count is nonzero
// - start needs end, nmi, error flags clear
// - request modes transfer only on request
// - clearing channel enable ends the sequence
// - address error suspends transfers until cleared
`timescale 1ns/100ps
`default_nettype none
module dmace_channel (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_req_n,
  input wire logic periph_req,
  input wire logic nmi_in,
  input wire logic addr_err_in,
  output logic xfer_strobe,
  output logic busy,
  output logic transfer_done_irq,
  output logic irq
);

  // clear-after-read qualifier for the three software-cleared flags
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic wr, input logic wbit,
                                     input logic armed);
    flag_next = set | (cur & ~(wr & ~wbit & armed));
  endfunction

  // arming follows what software actually saw on the bus
  function automatic logic arm_next(input logic armed, input logic rd,
                                    input logic seen, input logic wr,
                                    input logic wbit);
    if (rd && seen) begin
      arm_next = 1'b1;
    end else if (wr && !wbit) begin
      arm_next = 1'b0;
    end else begin
      arm_next = armed;
    end
  endfunction

  dmace_pkg::dmace_ctrl_s ctrl_q, ctrl_d;
  dmace_pkg::dmace_oper_s oper_q, oper_d;
  dmace_pkg::dmace_state_e state_q, state_d;
  logic [15:0] count_q, count_d;
  logic [2:0] stat_q, stat_d, mask_q, mask_d;
  logic te_arm_q, te_arm_d, nmi_arm_q, nmi_arm_d, ae_arm_q, ae_arm_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic strobe_q, strobe_d, busy_q, busy_d, dirq_q, dirq_d, irq_q, irq_d;
  logic req_s1_q, req_s2_q, nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic acc, wr, rd, hit, wr_ctrl, wr_oper, rd_ctrl, rd_oper;
  logic nmi_ev, ae_ev, req_now, enabled, flags_clear, done;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end else begin
      req_s1_q <= ~ext_req_n;
      req_s2_q <= req_s1_q;
      nmi_s1_q <= nmi_in;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  // apb decode; one wait state so prdata can come from a flop
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit = (paddr == dmace_pkg::OFF_CTRL) ||
               (paddr == dmace_pkg::OFF_OPER) ||
               (paddr == dmace_pkg::OFF_COUNT) ||
               (paddr == dmace_pkg::OFF_STAT) ||
               (paddr == dmace_pkg::OFF_MASK);
  assign wr_ctrl = wr & (paddr == dmace_pkg::OFF_CTRL);
  assign wr_oper = wr & (paddr == dmace_pkg::OFF_OPER);
  assign rd_ctrl = rd & (paddr == dmace_pkg::OFF_CTRL);
  assign rd_oper = rd & (paddr == dmace_pkg::OFF_OPER);

  // events: nmi on its rising edge, bus error only while moving data
  assign nmi_ev = nmi_s2_q & ~nmi_s3_q;
  assign ae_ev = addr_err_in & (state_q == dmace_pkg::ST_RUN);

  // request source per mode; auto needs no outside request
  always_comb begin
    unique case (ctrl_q.mode)
      dmace_pkg::MODE_AUTO: req_now = 1'b1;
      dmace_pkg::MODE_EXT: req_now = req_s2_q;
      dmace_pkg::MODE_PERIPH: req_now = periph_req;
      default: req_now = 1'b0;
    endcase
  end

  assign enabled = ctrl_q.go & oper_q.global_dma_on;
  // a pending error or nmi this cycle already counts as set
  assign flags_clear = ~ctrl_q.te & ~oper_q.nmi_abort_flag & ~oper_q.ae &
                       ~nmi_ev & ~ae_ev;
  assign done = (state_q == dmace_pkg::ST_RUN) & enabled & flags_clear &
                req_now & (count_q == dmace_pkg::CNT_ONE);

  // transfer engine
  always_comb begin
    state_d = state_q;
    strobe_d = 1'b0;
    count_d = count_q;
    unique case (state_q)
      dmace_pkg::ST_IDLE: begin
        // a zero count means nothing to move, so no start
        if (enabled && flags_clear &&
            count_q != dmace_pkg::CNT_RST) begin
          state_d = dmace_pkg::ST_RUN;
        end
        if (wr && paddr == dmace_pkg::OFF_COUNT) begin
          count_d = pwdata[dmace_pkg::CNT_W-1:0];
        end
      end
      dmace_pkg::ST_RUN: begin
        if (!enabled || !flags_clear) begin
          state_d = dmace_pkg::ST_IDLE;
        end else if (req_now) begin
          strobe_d = 1'b1;
          count_d = count_q - dmace_pkg::CNT_ONE;
          if (done) begin
            state_d = dmace_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // control, operation and interrupt registers; hardware set beats clear
  always_comb begin
    ctrl_d = ctrl_q;
    oper_d = oper_q;
    mask_d = mask_q;
    if (wr_ctrl) begin
      ctrl_d.go = pwdata[dmace_pkg::CTRL_GO_BIT];
      ctrl_d.ie = pwdata[dmace_pkg::CTRL_IE_BIT];
      ctrl_d.mode = pwdata[dmace_pkg::CTRL_MODE_LSB +: 2];
    end
    ctrl_d.te = flag_next(ctrl_q.te, done, wr_ctrl,
                          pwdata[dmace_pkg::CTRL_TE_BIT],
                          te_arm_q);
    if (wr_oper) begin
      oper_d.global_dma_on = pwdata[dmace_pkg::OPER_DME_BIT];
    end
    oper_d.nmi_abort_flag = flag_next(oper_q.nmi_abort_flag, nmi_ev, wr_oper,
                            pwdata[dmace_pkg::OPER_NMI_BIT], nmi_arm_q);
    oper_d.ae = flag_next(oper_q.ae, ae_ev, wr_oper,
                          pwdata[dmace_pkg::OPER_AE_BIT],
                          ae_arm_q);
    te_arm_d = arm_next(te_arm_q, rd_ctrl,
                        prdata_q[dmace_pkg::CTRL_TE_BIT], wr_ctrl,
                        pwdata[dmace_pkg::CTRL_TE_BIT]);
    nmi_arm_d = arm_next(nmi_arm_q, rd_oper,
                         prdata_q[dmace_pkg::OPER_NMI_BIT], wr_oper,
                         pwdata[dmace_pkg::OPER_NMI_BIT]);
    ae_arm_d = arm_next(ae_arm_q, rd_oper,
                        prdata_q[dmace_pkg::OPER_AE_BIT], wr_oper,
                        pwdata[dmace_pkg::OPER_AE_BIT]);
    stat_d = stat_q;
    if (wr && paddr == dmace_pkg::OFF_STAT) begin
      stat_d = stat_q & ~pwdata[dmace_pkg::EV_W-1:0];
    end
    if (wr && paddr == dmace_pkg::OFF_MASK) begin
      mask_d = pwdata[dmace_pkg::EV_W-1:0];
    end
    stat_d[dmace_pkg::EV_DONE] = stat_d[dmace_pkg::EV_DONE] | done;
    stat_d[dmace_pkg::EV_NMI] = stat_d[dmace_pkg::EV_NMI] | nmi_ev;
    stat_d[dmace_pkg::EV_AE] = stat_d[dmace_pkg::EV_AE] | ae_ev;
    // outputs registered from next values so they track the flags exactly
    dirq_d = ctrl_d.te & ctrl_d.ie;
    irq_d = |(stat_d & mask_d);
    busy_d = (state_d == dmace_pkg::ST_RUN);
  end

  // apb answer: pready one cycle into the access phase
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel && penable && !pready_q) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = ~hit; // unmapped addresses read zero and flag an error
      unique case (paddr)
        dmace_pkg::OFF_CTRL: begin
          prdata_d[dmace_pkg::CTRL_GO_BIT] = ctrl_q.go;
          prdata_d[dmace_pkg::CTRL_TE_BIT] = ctrl_d.te;
          prdata_d[dmace_pkg::CTRL_IE_BIT] = ctrl_q.ie;
          prdata_d[dmace_pkg::CTRL_MODE_LSB +: 2] = ctrl_q.mode;
        end
        dmace_pkg::OFF_OPER: begin
          prdata_d[dmace_pkg::OPER_DME_BIT] = oper_q.global_dma_on;
          prdata_d[dmace_pkg::OPER_NMI_BIT] = oper_d.nmi_abort_flag;
          prdata_d[dmace_pkg::OPER_AE_BIT] = oper_d.ae;
        end
        dmace_pkg::OFF_COUNT: prdata_d[dmace_pkg::CNT_W-1:0] = count_q;
        dmace_pkg::OFF_STAT: prdata_d[dmace_pkg::EV_W-1:0] = stat_q;
        dmace_pkg::OFF_MASK: prdata_d[dmace_pkg::EV_W-1:0] = mask_q;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // state registers; reset clears all of them except state_q, which loads ST_IDLE (2'b01)
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= dmace_pkg::ST_IDLE;
      count_q <= dmace_pkg::CNT_RST;
      ctrl_q <= dmace_pkg::CTRL_RST;
      oper_q <= dmace_pkg::OPER_RST;
      stat_q <= dmace_pkg::EV_RST;
      mask_q <= dmace_pkg::EV_RST;
      te_arm_q <= 1'b0;
      nmi_arm_q <= 1'b0;
      ae_arm_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      strobe_q <= 1'b0;
      busy_q <= 1'b0;
      dirq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      ctrl_q <= ctrl_d;
      oper_q <= oper_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      te_arm_q <= te_arm_d;
      nmi_arm_q <= nmi_arm_d;
      ae_arm_q <= ae_arm_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      strobe_q <= strobe_d;
      busy_q <= busy_d;
      dirq_q <= dirq_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign xfer_strobe = strobe_q;
  assign busy = busy_q;
  assign transfer_done_irq = dirq_q;
  assign irq = irq_q;

  // checks on the channel's own behaviour
  sequence s_can_start;
    state_q == dmace_pkg::ST_IDLE && enabled && flags_clear &&
    count_q != dmace_pkg::CNT_RST;
  endsequence

  sequence s_last_beat;
    done ##1 (transfer_done_irq == ctrl_q.ie);
  endsequence

  property p_irq_gated;
    @(posedge clk) disable iff (srst)
    ctrl_q.te && !ctrl_q.ie |-> !transfer_done_irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("done irq raised while disabled");

  property p_end_sets_flag;
    @(posedge clk) disable iff (srst)
    s_last_beat |-> ctrl_q.te && xfer_strobe && count_q == 16'h0000;
  endproperty
  a_end_sets_flag: assert property (p_end_sets_flag)
    else $error("last transfer did not set end flag");

  property p_abort_no_flag;
    @(posedge clk) disable iff (srst)
    state_q == dmace_pkg::ST_RUN && !ctrl_q.te && (nmi_ev || ae_ev)
    |=> !ctrl_q.te && state_q == dmace_pkg::ST_IDLE && !xfer_strobe;
  endproperty
  a_abort_no_flag: assert property (p_abort_no_flag)
    else $error("abort set end flag or kept running");

  property p_stop_no_flag;
    @(posedge clk) disable iff (srst)
    state_q == dmace_pkg::ST_RUN && !ctrl_q.te && !enabled
    |=> !ctrl_q.te && state_q == dmace_pkg::ST_IDLE && !xfer_strobe;
  endproperty
  a_stop_no_flag: assert property (p_stop_no_flag)
    else $error("software stop set end flag");

  property p_flags_block;
    @(posedge clk) disable iff (srst)
    state_q == dmace_pkg::ST_IDLE &&
    (ctrl_q.te || oper_q.nmi_abort_flag || oper_q.ae) |=> !busy ##1 !xfer_strobe;
  endproperty
  a_flags_block: assert property (p_flags_block)
    else $error("channel started with a flag set");

  property p_flag_holds;
    @(posedge clk) disable iff (srst)
    ctrl_q.te && !te_arm_q |=> ctrl_q.te;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("end flag cleared without prior read");

  property p_auto_start;
    @(posedge clk) disable iff (srst)
    s_can_start |=> busy;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("channel failed to start");

  property p_start_needs_clear;
    @(posedge clk) disable iff (srst)
    $rose(busy) |-> $past(flags_clear) && $past(enabled);
  endproperty
  a_start_needs_clear: assert property (p_start_needs_clear)
    else $error("start without clear flags");

  property p_req_only;
    @(posedge clk) disable iff (srst)
    ctrl_q.mode != dmace_pkg::MODE_AUTO && !req_now |=> !xfer_strobe;
  endproperty
  a_req_only: assert property (p_req_only)
    else $error("transfer without request");

  property p_go_off;
    @(posedge clk) disable iff (srst)
    !ctrl_q.go |=> !xfer_strobe;
  endproperty
  a_go_off: assert property (p_go_off)
    else $error("transfer after channel disabled");

  property p_ae_suspend;
    @(posedge clk) disable iff (srst)
    oper_q.ae |=> !xfer_strobe && !busy;
  endproperty
  a_ae_suspend: assert property (p_ae_suspend)
    else $error("transfer during address error");

  property p_irq_level;
    @(posedge clk) disable iff (srst)
    ctrl_q.te && ctrl_q.ie |-> transfer_done_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("done irq not held");

endmodule
`default_nettype wire

/* dmace_channel_test.sv */
// self-checking bench for the dma channel control block
// assumes dmace_pkg and dmace_channel are compiled first, one clock domain
`timescale 1ns/100ps
`default_nettype none
module dmace_channel_test;
  localparam logic [31:0] TE_M = 32'h1 << dmace_pkg::CTRL_TE_BIT;
  localparam logic [31:0] DME_M = 32'h1 << dmace_pkg::OPER_DME_BIT;
  localparam logic [31:0] NMI_M = 32'h1 << dmace_pkg::OPER_NMI_BIT;
  localparam logic [31:0] AE_M = 32'h1 << dmace_pkg::OPER_AE_BIT;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_req_n = 1'b1;
  logic periph_req = 1'b0;
  logic nmi_in = 1'b0;
  logic addr_err_in = 1'b0;
  logic xfer_strobe;
  logic busy;
  logic transfer_done_irq;
  logic irq;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int mismatches = 0;
  int comparisons = 0;
  int strobes = 0;
  logic [31:0] seed = 32'h90f84c2c;

  // 20 MHz clock
  always #25 clk = ~clk;

  dmace_channel u_dmace_channel (.clk(clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_req_n(ext_req_n), .periph_req(periph_req), .nmi_in(nmi_in),
    .addr_err_in(addr_err_in), .xfer_strobe(xfer_strobe), .busy(busy),
    .transfer_done_irq(transfer_done_irq), .irq(irq));

  // xorshift source, fixed seed so every run repeats
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ctl(input logic go, input logic ie,
                                      input logic [1:0] mode);
    return (32'(go) << dmace_pkg::CTRL_GO_BIT) |
           (32'(ie) << dmace_pkg::CTRL_IE_BIT) |
           (32'(mode) << dmace_pkg::CTRL_MODE_LSB);
  endfunction

  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; the trailing idle edge keeps strobes single-driven
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [32:0] e);
    int n;
    n = 0;
    if (!wr) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0, m, {1'b0, e});
  endtask

  task automatic idle_wait();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) mismatches++;
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watcher: oldest read note against each completed read, strobe count
  always @(posedge clk) begin : mon
    logic [31:0] m;
    logic [32:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      cmp({pslverr, prdata & m}, {e[32], e[31:0] & m});
    end
    if (xfer_strobe === 1'b1) strobes++;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(50 * 20000);
    mismatches++;
    tally_and_finish();
  end

  initial begin : main
    logic [7:0] offs[5];
    int n;
    int k;
    int s0;
    logic [1:0] md;
    offs = '{dmace_pkg::OFF_CTRL, dmace_pkg::OFF_OPER, dmace_pkg::OFF_COUNT,
             dmace_pkg::OFF_STAT, dmace_pkg::OFF_MASK};
    tick(8);
    srst <= 1'b0;
    tick(1);
    chk(busy, 1'b0);
    chk(transfer_done_irq, 1'b0);
    chk(irq, 1'b0);
    for (int i = 0; i < 5; i++) rd(offs[i], 32'hffffffff, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'hffffffff, {1'b1, 32'h0});
    $display("test reset values done");
    // auto mode with the end irq enabled, then disabled
    for (int j = 0; j < 2; j++) begin
      n = int'(rnd() % 8) + 1;
      s0 = strobes;
      wr(dmace_pkg::OFF_COUNT, 32'(n));
      wr(dmace_pkg::OFF_MASK, 32'h7);
      wr(dmace_pkg::OFF_OPER, DME_M);
      wr(dmace_pkg::OFF_CTRL, ctl(1'b1, j == 0, dmace_pkg::MODE_AUTO));
      tick(1);
      idle_wait();
      tick(1);
      cmp(33'(strobes - s0), 33'(n));
      chk(transfer_done_irq, j == 0);
      chk(irq, 1'b1);
      rd(dmace_pkg::OFF_COUNT, 32'hffff, 32'h0);
      // flag not yet read: a zero write must not clear it or restart
      wr(dmace_pkg::OFF_COUNT, 32'h5);
      wr(dmace_pkg::OFF_CTRL, ctl(1'b1, j == 0, dmace_pkg::MODE_AUTO));
      tick(10);
      chk(busy, 1'b0);
      cmp(33'(strobes - s0), 33'(n));
      rd(dmace_pkg::OFF_CTRL, TE_M, TE_M);
      wr(dmace_pkg::OFF_CTRL, ctl(1'b0, j == 0, dmace_pkg::MODE_AUTO));
      rd(dmace_pkg::OFF_CTRL, TE_M, 32'h0);
      chk(transfer_done_irq, 1'b0);
      wr(dmace_pkg::OFF_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(dmace_pkg::OFF_MASK, 32'h7);
      chk(irq, 1'b1);
      wr(dmace_pkg::OFF_STAT, 32'h1);
      chk(irq, 1'b0);
    end
    $display("test auto transfers done");
    // request modes; both sources pulse so only the selected one counts
    for (int j = 1; j < 4; j++) begin
      md = 2'(j);
      k = int'(rnd() % 4) + 1;
      wr(dmace_pkg::OFF_COUNT, 32'd100);
      wr(dmace_pkg::OFF_OPER, DME_M);
      wr(dmace_pkg::OFF_CTRL, ctl(1'b1, 1'b0, md));
      s0 = strobes;
      tick(6);
      cmp(33'(strobes - s0), 33'h0);
      repeat (k) begin
        ext_req_n <= 1'b0;
        periph_req <= 1'b1;
        tick(1);
        ext_req_n <= 1'b1;
        periph_req <= 1'b0;
        tick(5);
      end
      n = (md == 2'h3) ? 0 : k;
      cmp(33'(strobes - s0), 33'(n));
      chk(busy, 1'b1);
      if (md == dmace_pkg::MODE_EXT)
        wr(dmace_pkg::OFF_CTRL, ctl(1'b0, 1'b0, md));
      else
        wr(dmace_pkg::OFF_OPER, 32'h0);
      tick(2);
      chk(busy, 1'b0);
      rd(dmace_pkg::OFF_CTRL, TE_M, 32'h0);
      rd(dmace_pkg::OFF_COUNT, 32'hffff, 32'(100 - n));
    end
    wr(dmace_pkg::OFF_CTRL, 32'h0);
    $display("test request modes done");
    // nmi abort, then address error, each blocking until cleared
    wr(dmace_pkg::OFF_COUNT, 32'd400);
    wr(dmace_pkg::OFF_OPER, DME_M);
    wr(dmace_pkg::OFF_CTRL, ctl(1'b1, 1'b1, dmace_pkg::MODE_AUTO));
    tick(5);
    chk(busy, 1'b1);
    nmi_in <= 1'b1;
    tick(4);
    nmi_in <= 1'b0;
    idle_wait();
    tick(1);
    rd(dmace_pkg::OFF_OPER, NMI_M | AE_M, NMI_M);
    rd(dmace_pkg::OFF_CTRL, TE_M, 32'h0);
    rd(dmace_pkg::OFF_STAT, 32'h2, 32'h2);
    tick(10);
    chk(busy, 1'b0);
    wr(dmace_pkg::OFF_OPER, DME_M);
    tick(3);
    chk(busy, 1'b1);
    addr_err_in <= 1'b1;
    tick(1);
    addr_err_in <= 1'b0;
    idle_wait();
    tick(1);
    rd(dmace_pkg::OFF_OPER, NMI_M | AE_M, AE_M);
    rd(dmace_pkg::OFF_CTRL, TE_M, 32'h0);
    tick(10);
    chk(busy, 1'b0);
    wr(dmace_pkg::OFF_OPER, DME_M);
    tick(3);
    chk(busy, 1'b1);
    wr(dmace_pkg::OFF_CTRL, 32'h0);
    tick(2);
    chk(busy, 1'b0);
    rd(dmace_pkg::OFF_CTRL, TE_M, 32'h0);
    chk(transfer_done_irq, 1'b0);
    $display("test aborts done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
